// file: inc/rlyc_defines.vh
`ifndef RLYC_DEFINES_VH
`define RLYC_DEFINES_VH
// register offsets (byte addresses, one word each)
`define RLYC_A_CTRL 8'h00
`define RLYC_A_THR1 8'h04
`define RLYC_A_THR2 8'h08
`define RLYC_A_DEADBAND_HALF_WIDTH 8'h0c
`define RLYC_A_GATE 8'h10
`define RLYC_A_DLY 8'h14
`define RLYC_A_SPAN 8'h18
`define RLYC_A_PER 8'h1c
`define RLYC_A_MIN 8'h20
`define RLYC_A_BUSV 8'h24
`define RLYC_A_STAT 8'h28
// ctrl fields
`define RLYC_F_SRC 1:0
`define RLYC_F_MODE 4:2
`define RLYC_F_UNIT 5
`define RLYC_F_FAULT 7:6
`define RLYC_F_PWMAL 8
`define RLYC_F_DUTY 15:9
// source select
`define RLYC_SRC_MEAS 2'h0
`define RLYC_SRC_BUS 2'h1
`define RLYC_SRC_HEAT 2'h2
`define RLYC_SRC_COOL 2'h3
// modes
`define RLYC_M_DIS 3'h0
`define RLYC_M_DIR 3'h1
`define RLYC_M_INV 3'h2
`define RLYC_M_IN 3'h3
`define RLYC_M_OUT 3'h4
`define RLYC_M_PWM 3'h5
// fault reaction
`define RLYC_AL_HOLD 2'h0
`define RLYC_AL_ON 2'h1
`define RLYC_AL_OFF 2'h2
// limits
`define RLYC_THR_MIN (-14'sd999)
`define RLYC_THR_MAX 14'sd9999
`define RLYC_HYS_MAX 10'h3e7
`define RLYC_DLY_MAX 10'h3e7
`define RLYC_PER_MAX 14'h270f
`define RLYC_CTRL_RST 16'h0000
// timebase: 0.1 s tick at 40 MHz
`define RLYC_TICK_NS 100000000
`define RLYC_CLK_NS 25
`define RLYC_TICK_CYC (`RLYC_TICK_NS / `RLYC_CLK_NS)
// one 0.1 min delay step in 0.1 s ticks
`define RLYC_MIN_TICKS 60
`endif

// file: rtl/rlyc_relay_ctrl.v
`timescale 1ns/1ps
`include "rlyc_defines.vh"
module rlyc_relay_ctrl #(
  parameter TICK_CYC = `RLYC_TICK_CYC,
  parameter OC_OUTPUT = 1
) (
  input wire mclk,
  input wire resetn,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire signed [13:0] meas_value,
  input wire meas_range_fault,
  input wire signed [13:0] heat_deviation,
  input wire [6:0] heat_output_pct,
  input wire signed [13:0] cool_deviation,
  input wire [6:0] cool_output_pct,
  output reg relay_out,
  output reg led_out
);
  reg [15:0] ctrl_r;
  reg signed [13:0] thr1_r;
  reg signed [13:0] thr2_r;
  reg [9:0] deadband_half_width_r;
  reg [13:0] dev_gate_r;
  reg [6:0] pct_gate_r;
  reg [9:0] on_dly_r;
  reg [9:0] off_dly_r;
  reg signed [13:0] span_lo_r;
  reg signed [13:0] span_hi_r;
  reg [13:0] period_r;
  reg [13:0] hmin_r;
  reg [13:0] lmin_r;
  reg signed [13:0] bus_value_r;
  reg [23:0] pre_r;
  reg [9:0] minpre_r;
  reg [15:0] dly_cnt_r;
  reg [13:0] pcnt_r;
  reg rly_r;
  reg pwm_r;
  reg tick;
  wire [1:0] src = ctrl_r[`RLYC_F_SRC];
  wire [2:0] mode = ctrl_r[`RLYC_F_MODE];
  wire [1:0] fault_reaction = ctrl_r[`RLYC_F_FAULT];
  wire pwm_fault_fill = ctrl_r[`RLYC_F_PWMAL];
  wire [6:0] forced_fill = ctrl_r[`RLYC_F_DUTY];
  wire pwm_drive_mode = (mode == `RLYC_M_PWM) && (OC_OUTPUT != 0);
  // clamp helper for signed thresholds
  function signed [13:0] clamp_thr;
    input signed [31:0] v;
    begin
      if (v < -999)
        clamp_thr = `RLYC_THR_MIN;
      else if (v > 9999)
        clamp_thr = `RLYC_THR_MAX;
      else
        clamp_thr = v[13:0];
    end
  endfunction
  // bus register writes
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= `RLYC_CTRL_RST;
      thr1_r <= 14'sd0;
      thr2_r <= 14'sd0;
      deadband_half_width_r <= 10'h000;
      dev_gate_r <= 14'h0000;
      pct_gate_r <= 7'h00;
      on_dly_r <= 10'h000;
      off_dly_r <= 10'h000;
      span_lo_r <= 14'sd0;
      span_hi_r <= 14'sd0;
      period_r <= 14'h0000;
      hmin_r <= 14'h0000;
      lmin_r <= 14'h0000;
      bus_value_r <= 14'sd0;
    end else if (wr) begin
      case (addr)
        `RLYC_A_CTRL: ctrl_r <= wdata[15:0];
        `RLYC_A_THR1: thr1_r <= clamp_thr(wdata);
        `RLYC_A_THR2: thr2_r <= clamp_thr(wdata);
        `RLYC_A_DEADBAND_HALF_WIDTH: begin
          // whole word compared so large values clamp instead of wrapping
          if (wdata > {22'h000000, `RLYC_HYS_MAX})
            deadband_half_width_r <= `RLYC_HYS_MAX;
          else
            deadband_half_width_r <= wdata[9:0];
        end
        `RLYC_A_GATE: begin
          dev_gate_r <= wdata[13:0];
          pct_gate_r <= wdata[22:16];
        end
        `RLYC_A_DLY: begin
          if (wdata[15:0] > {6'h00, `RLYC_DLY_MAX})
            on_dly_r <= `RLYC_DLY_MAX;
          else
            on_dly_r <= wdata[9:0];
          if (wdata[31:16] > {6'h00, `RLYC_DLY_MAX})
            off_dly_r <= `RLYC_DLY_MAX;
          else
            off_dly_r <= wdata[25:16];
        end
        `RLYC_A_SPAN: begin
          span_lo_r <= wdata[13:0];
          span_hi_r <= wdata[29:16];
        end
        `RLYC_A_PER: begin
          if (wdata > {18'h00000, `RLYC_PER_MAX})
            period_r <= `RLYC_PER_MAX;
          else
            period_r <= wdata[13:0];
        end
        `RLYC_A_MIN: begin
          hmin_r <= wdata[13:0];
          lmin_r <= wdata[29:16];
        end
        `RLYC_A_BUSV: bus_value_r <= wdata[13:0];
        default: ;
      endcase
    end
  end
  // reads: data in the cycle after the strobe, unmapped reads zero
  always @(posedge mclk or negedge resetn) begin
    if (!resetn)
      rdata <= 32'h0000_0000;
    else if (rd) begin
      case (addr)
        `RLYC_A_CTRL: rdata <= {16'h0000, ctrl_r};
        `RLYC_A_THR1: rdata <= {{18{thr1_r[13]}}, thr1_r};
        `RLYC_A_THR2: rdata <= {{18{thr2_r[13]}}, thr2_r};
        `RLYC_A_DEADBAND_HALF_WIDTH: rdata <= {22'h000000, deadband_half_width_r};
        `RLYC_A_GATE: rdata <= {9'h000, pct_gate_r, 2'h0, dev_gate_r};
        `RLYC_A_DLY: rdata <= {6'h00, off_dly_r, 6'h00, on_dly_r};
        `RLYC_A_SPAN: rdata <= {2'h0, span_hi_r, 2'h0, span_lo_r};
        `RLYC_A_PER: rdata <= {18'h00000, period_r};
        `RLYC_A_MIN: rdata <= {2'h0, lmin_r, 2'h0, hmin_r};
        `RLYC_A_BUSV: rdata <= {{18{bus_value_r[13]}}, bus_value_r};
        `RLYC_A_STAT: rdata <= {28'h0000000, meas_range_fault,
                                pwm_r, rly_r, relay_out};
        default: rdata <= 32'h0000_0000;
      endcase
    end else
      rdata <= 32'h0000_0000;
  end
  // source selection and loop gating
  reg signed [13:0] src_val;
  reg loop_ok;
  reg [13:0] dev_abs;
  reg [6:0] pct;
  always @* begin
    src_val = meas_value;
    dev_abs = 14'h0000;
    pct = 7'h00;
    loop_ok = 1'b1;
    case (src)
      `RLYC_SRC_MEAS: src_val = meas_value;
      `RLYC_SRC_BUS: src_val = bus_value_r;
      `RLYC_SRC_HEAT: begin
        src_val = heat_deviation;
        pct = heat_output_pct;
      end
      default: begin
        src_val = cool_deviation;
        pct = cool_output_pct;
      end
    endcase
    if (src[1]) begin
      dev_abs = src_val[13] ? (~src_val + 14'h0001) : src_val;
      // both gates must pass when both are set
      loop_ok = ((dev_gate_r == 14'h0000) || (dev_abs >= dev_gate_r)) &&
                ((pct_gate_r == 7'h00) || (pct >= pct_gate_r));
    end
  end
  // borders, widened so threshold +/- hysteresis never wraps
  wire signed [15:0] sv = {{2{src_val[13]}}, src_val};
  wire signed [15:0] h = {6'h00, deadband_half_width_r};
  wire signed [15:0] t1 = {{2{thr1_r[13]}}, thr1_r};
  wire signed [15:0] t2 = {{2{thr2_r[13]}}, thr2_r};
  wire signed [15:0] tlo = (t1 < t2) ? t1 : t2;
  wire signed [15:0] thi = (t1 < t2) ? t2 : t1;
  // want_on/want_off: border crossed towards on/off state
  reg want_on;
  reg want_off;
  always @* begin
    want_on = 1'b0;
    want_off = 1'b0;
    case (mode)
      `RLYC_M_DIR: begin
        want_on = sv > t1 + h;
        want_off = sv < t1 - h;
      end
      `RLYC_M_INV: begin
        want_off = sv > t1 + h;
        want_on = sv < t1 - h;
      end
      `RLYC_M_IN: begin
        want_on = (sv > tlo + h) && (sv < thi - h);
        want_off = !want_on;
      end
      `RLYC_M_OUT: begin
        want_on = (sv > thi + h) || (sv < tlo - h);
        want_off = !want_on;
      end
      default: begin
        want_on = 1'b0;
        want_off = 1'b1;
      end
    endcase
    if (!loop_ok) begin
      want_on = 1'b0;
      want_off = 1'b0;
    end
  end
  // 0.1 s timebase; a minute-unit delay step is 60 of these ticks
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre_r <= 24'h000000;
      tick <= 1'b0;
    end else if (pre_r == TICK_CYC - 1) begin
      pre_r <= 24'h000000;
      tick <= 1'b1;
    end else begin
      pre_r <= pre_r + 24'h000001;
      tick <= 1'b0;
    end
  end
  always @(posedge mclk or negedge resetn) begin
    if (!resetn)
      minpre_r <= 10'h000;
    else if (tick)
      minpre_r <= (minpre_r == `RLYC_MIN_TICKS - 1) ? 10'h000 :
                  minpre_r + 10'h001;
  end
  wire dly_tick = ctrl_r[`RLYC_F_UNIT] ? (tick && minpre_r == 10'h000)
                  : tick;
  // delayed relay state
  wire pending = rly_r ? want_off : want_on;
  wire [9:0] dly_lim = rly_r ? off_dly_r : on_dly_r;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dly_cnt_r <= 16'h0000;
      rly_r <= 1'b0;
    end else if (mode == `RLYC_M_DIS || pwm_drive_mode) begin
      dly_cnt_r <= 16'h0000;
      rly_r <= 1'b0;
    end else if (!pending) begin
      dly_cnt_r <= 16'h0000;
    end else if (dly_lim == 10'h000 ||
                 dly_cnt_r > {6'h00, dly_lim}) begin
      // one extra tick: a partial first tick never shortens the delay
      rly_r <= ~rly_r;
      dly_cnt_r <= 16'h0000;
    end else if (dly_tick)
      dly_cnt_r <= dly_cnt_r + 16'h0001;
  end
  // pwm fill in percent: linear across the span
  reg [6:0] fill;
  reg signed [15:0] num;
  reg signed [15:0] den;
  reg [22:0] prod;
  reg [22:0] quo;
  always @* begin
    num = sv - {{2{span_lo_r[13]}}, span_lo_r};
    den = {{2{span_hi_r[13]}}, span_hi_r} -
          {{2{span_lo_r[13]}}, span_lo_r};
    prod = 23'h000000;
    quo = 23'h000000;
    if (num <= 0)
      fill = 7'h00;
    else if (num >= den)
      fill = 7'h64;
    else begin
      prod = num[15:0] * 7'h64;
      quo = prod / den[15:0];
      fill = quo[6:0];
    end
    if (meas_range_fault && pwm_fault_fill) begin
      // codes above 100 % would push the high time past the period
      if (forced_fill > 7'h64)
        fill = 7'h64;
      else
        fill = forced_fill;
    end
  end
  // high time in 0.1 s ticks for this period
  wire [20:0] hraw = period_r * fill;
  wire [20:0] hq = hraw / 21'h64;
  wire [13:0] htime_raw = hq[13:0];
  reg [13:0] htime;
  always @* begin
    htime = htime_raw;
    if (htime != 14'h0000 && htime < hmin_r)
      htime = hmin_r;
    if (htime != period_r && period_r - htime < lmin_r)
      htime = period_r - lmin_r;
    if ({1'b0, hmin_r} + {1'b0, lmin_r} > {1'b0, period_r})
      htime = 14'h0000;
  end
  // per-period counter, minimum times re-evaluated each period
  reg [13:0] htime_r;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pcnt_r <= 14'h0000;
      htime_r <= 14'h0000;
      pwm_r <= 1'b0;
    end else if (!pwm_drive_mode) begin
      pcnt_r <= 14'h0000;
      htime_r <= 14'h0000;
      pwm_r <= 1'b0;
    end else begin
      if (tick) begin
        if (pcnt_r + 14'h0001 >= period_r) begin
          pcnt_r <= 14'h0000;
          // fault with hold keeps last period's share
          if (!(meas_range_fault && !pwm_fault_fill))
            htime_r <= htime;
        end else
          pcnt_r <= pcnt_r + 14'h0001;
      end
      pwm_r <= (period_r != 14'h0000) && (pcnt_r < htime_r);
    end
  end
  // alarm override and pin drive
  reg drive;
  always @* begin
    drive = pwm_drive_mode ? pwm_r : rly_r;
    if (meas_range_fault && !pwm_drive_mode) begin
      case (fault_reaction)
        `RLYC_AL_ON: drive = 1'b1;
        `RLYC_AL_OFF: drive = 1'b0;
        // hold applies to active modes only, disabled stays off
        default: drive = (mode == `RLYC_M_DIS) ? 1'b0 : relay_out;
      endcase
    end
  end
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      relay_out <= 1'b0;
      led_out <= 1'b0;
    end else begin
      relay_out <= drive;
      led_out <= drive;
    end
  end
endmodule

// file: testbench/rlyc_load_model.sv
`timescale 1ns/1ps
module rlyc_load_model (
  input wire mclk,
  input wire resetn,
  input wire relay_out,
  input wire led_out,
  output logic coil_closed,
  output logic lamp_lit,
  output logic [15:0] close_count
);
  // no contact bounce modelled, so any chatter shows as extra closures
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      coil_closed <= 1'b0;
      lamp_lit <= 1'b0;
      close_count <= 16'h0000;
    end else begin
      coil_closed <= relay_out;
      lamp_lit <= led_out;
      if (relay_out && !coil_closed) begin
        close_count <= close_count + 16'h0001;
      end
    end
  end
endmodule

// file: testbench/rlyc_relay_ctrl_monitor.sv
`timescale 1ns/1ps
module rlyc_relay_ctrl_chk #(
  parameter TICK_CYC = 4,
  parameter OC_OUTPUT = 1
) (
  input wire mclk,
  input wire resetn,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire meas_range_fault,
  input wire relay_out,
  input wire led_out
);
  logic [15:0] ctrl_s;
  wire [2:0] md = ctrl_s[4:2];
  wire [1:0] fr = ctrl_s[7:6];
  wire rly = (md != 3'h0) && (md != 3'h5);
  // shadow of the control word, seen only through the bus
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_s <= 16'h0000;
    end else if (wr && addr == 8'h00) begin
      ctrl_s <= wdata[15:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  led_match_a: assert property (led_out == relay_out)
    else $error("led differs from relay");
  dis_off_a: assert property (
    (md == 3'h0 && !(meas_range_fault && fr == 2'h1))[*3] |-> !relay_out)
    else $error("relay on in disabled mode");
  fault_on_a: assert property (
    (meas_range_fault && fr == 2'h1 && md != 3'h5)[*3] |-> relay_out)
    else $error("force on ignored");
  dis_force_a: assert property (
    (meas_range_fault && fr == 2'h1 && md == 3'h0)[*3] |-> relay_out)
    else $error("force on ignored when disabled");
  fault_off_a: assert property (
    (meas_range_fault && fr == 2'h2 && md != 3'h5)[*3] |-> !relay_out)
    else $error("force off ignored");
  fault_hold_a: assert property (
    (meas_range_fault && fr == 2'h0 && rly)[*3] |-> $stable(relay_out))
    else $error("relay moved during held fault");
  rd_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  ctrl_back_a: assert property (
    $past(rd) && $past(addr) == 8'h00 |-> rdata[15:0] == ctrl_s)
    else $error("control readback wrong");
  cover property ($rose(relay_out));
  cover property (meas_range_fault && fr == 2'h1 && md == 3'h0 && relay_out);
  cover property (md == 3'h5 && $fell(relay_out));
endmodule
bind rlyc_relay_ctrl rlyc_relay_ctrl_chk #(.TICK_CYC(TICK_CYC),
  .OC_OUTPUT(OC_OUTPUT)) u_chk (.mclk(mclk), .resetn(resetn),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .meas_range_fault(meas_range_fault), .relay_out(relay_out),
  .led_out(led_out));

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [13:0] meas_value = 14'h0;
  logic meas_range_fault = 1'b0;
  logic [13:0] heat_deviation = 14'h0;
  logic [6:0] heat_output_pct = 7'h0;
  logic [13:0] cool_deviation = 14'h0;
  logic [6:0] cool_output_pct = 7'h0;
  wire [31:0] rdata;
  wire relay_out, led_out, coil_closed, lamp_lit;
  wire [15:0] close_count;
  logic [15:0] c0;
  int n_mismatch = 0;
  int compares = 0;
  int hi;
  always #12.5 mclk = ~mclk;
  // short tick keeps delay and period tests within a few thousand cycles
  rlyc_relay_ctrl #(.TICK_CYC(4), .OC_OUTPUT(1)) DUT (.mclk(mclk),
    .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .meas_value(meas_value),
    .meas_range_fault(meas_range_fault), .heat_deviation(heat_deviation),
    .heat_output_pct(heat_output_pct), .cool_deviation(cool_deviation),
    .cool_output_pct(cool_output_pct), .relay_out(relay_out),
    .led_out(led_out));
  rlyc_load_model u_load (.mclk(mclk), .resetn(resetn),
    .relay_out(relay_out), .led_out(led_out), .coil_closed(coil_closed),
    .lamp_lit(lamp_lit), .close_count(close_count));
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic br(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata & m);
  endtask
  task automatic mv(input logic [13:0] v, input int n, input logic e);
    @(posedge mclk);
    meas_value <= v;
    repeat (n) @(posedge mclk);
    #1;
    chk("relay_out", {31'h0, e}, {31'h0, relay_out});
    chk("led_out", {31'h0, e}, {31'h0, led_out});
    chk("lamp_lit", {31'h0, e}, {31'h0, lamp_lit});
  endtask
  task automatic fl(input logic b);
    @(posedge mclk);
    meas_range_fault <= b;
  endtask
  // count high cycles over four periods after two settling periods
  task automatic pw(input logic [13:0] v, input int lo, h);
    @(posedge mclk);
    meas_value <= v;
    repeat (80) @(posedge mclk);
    hi = 0;
    repeat (160) begin
      @(posedge mclk);
      #1;
      hi += relay_out;
    end
    compares++;
    if (hi < lo || hi > h) begin
      n_mismatch++;
      $display("unexpected high count: expected %0d..%0d, seen %0d", lo, h,
        hi);
    end
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  task automatic stop_test;
    $display("compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    $display("unexpected run length: expected end, seen timeout");
    stop_test;
  end
  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    br(8'h00, 32'hffffffff, 32'h0);
    bw(8'h30, 32'hffff);
    br(8'h30, 32'hffffffff, 32'h0);
    bw(8'h04, 32'h4e20);
    br(8'h04, 32'h3fff, 32'h270f);
    bw(8'h04, 32'hfffff830);
    br(8'h04, 32'h3fff, 32'h3c19);
    bw(8'h0c, 32'h7d0);
    br(8'h0c, 32'h3ff, 32'h3e7);
    endt("registers");
    bw(8'h04, 32'h64);
    bw(8'h0c, 32'ha);
    bw(8'h00, 32'h04);
    mv(14'h69, 6, 0);
    mv(14'h6f, 6, 1);
    mv(14'h5f, 6, 1);
    mv(14'h59, 6, 0);
    bw(8'h00, 32'h08);
    mv(14'h6f, 6, 0);
    mv(14'h59, 6, 1);
    mv(14'h5f, 6, 1);
    bw(8'h04, 32'hc8);
    bw(8'h08, 32'h64);
    bw(8'h00, 32'h0c);
    mv(14'h96, 6, 1);
    mv(14'h5f, 6, 0);
    mv(14'hcd, 6, 0);
    bw(8'h00, 32'h10);
    mv(14'h96, 6, 0);
    mv(14'hd7, 6, 1);
    mv(14'h55, 6, 1);
    mv(14'h5f, 6, 0);
    endt("thresholds");
    bw(8'h14, 32'h00030003);
    bw(8'h00, 32'h04);
    mv(14'h55, 20, 0);
    c0 = close_count;
    mv(14'hd7, 7, 0);
    mv(14'h55, 2, 0);
    mv(14'hd7, 7, 0);
    mv(14'hd7, 14, 1);
    mv(14'h55, 7, 1);
    mv(14'hd7, 2, 1);
    mv(14'h55, 7, 1);
    mv(14'h55, 14, 0);
    chk("close_count", c0 + 16'h1, close_count);
    bw(8'h14, 32'h1);
    bw(8'h00, 32'h24);
    mv(14'hd7, 235, 0);
    mv(14'hd7, 260, 1);
    bw(8'h14, 32'h0);
    mv(14'h0, 6, 0);
    endt("delays");
    bw(8'h04, 32'h64);
    bw(8'h24, 32'h96);
    bw(8'h00, 32'h05);
    mv(14'h0, 6, 1);
    bw(8'h00, 32'h06);
    mv(14'h0, 6, 0);
    bw(8'h10, 32'h001e0032);
    @(posedge mclk);
    heat_deviation <= 14'h96;
    heat_output_pct <= 7'h14;
    mv(14'h0, 6, 0);
    @(posedge mclk);
    heat_output_pct <= 7'h28;
    mv(14'h0, 6, 1);
    @(posedge mclk);
    cool_deviation <= 14'h3f6a;
    cool_output_pct <= 7'h28;
    bw(8'h00, 32'h07);
    mv(14'h0, 6, 0);
    @(posedge mclk);
    cool_deviation <= 14'h96;
    mv(14'h0, 6, 1);
    endt("sources");
    bw(8'h00, 32'h40);
    fl(1);
    mv(14'h0, 6, 1);
    fl(0);
    mv(14'h0, 6, 0);
    bw(8'h00, 32'h84);
    mv(14'h96, 6, 1);
    fl(1);
    mv(14'h96, 6, 0);
    fl(0);
    bw(8'h00, 32'h04);
    mv(14'h96, 6, 1);
    fl(1);
    mv(14'h0, 6, 1);
    fl(0);
    mv(14'h0, 6, 0);
    endt("faults");
    bw(8'h18, 32'h00c80064);
    bw(8'h1c, 32'ha);
    bw(8'h20, 32'h0);
    bw(8'h00, 32'h14);
    pw(14'h32, 0, 0);
    pw(14'hfa, 160, 160);
    pw(14'h96, 72, 88);
    bw(8'h20, 32'h8);
    pw(14'h6e, 120, 136);
    bw(8'h20, 32'h00060006);
    pw(14'h96, 0, 0);
    bw(8'h20, 32'h0);
    bw(8'h00, 32'hc914);
    fl(1);
    pw(14'h32, 160, 160);
    fl(0);
    endt("pwm");
    stop_test;
  end
endmodule
